// ---- src/undervoltage_protection_stages.sv ----
`timescale 1ns/100ps
// Contract
// - start when smallest voltage below pick-up
// - trip after start outlasts operate delay
// - block input stops start and trip, except while force flag set
// - self-block when largest voltage below limit
// - zero blocking limit disables self blocking
// - between limits counts as undervoltage, no memory
// - three stages, own settings, definite time
// - four setting groups, one active
// - group source none/digital/virtual/indicator/output
// - state idle, blocked, started or tripped
// - shared force flag, 5-minute self clear
// - release delay on first stage only
// - settings in 0.1 % of rated voltage, pick-up in primary volts
// - minimum line voltage shown in primary volts
// - eight-entry fault log per stage
// - elapsed delay as percent, 100 = trip
// - pre-fault value is 1 s average
module undervoltage_protection_stages
    import uv_prot_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int FORCE_TICKS = FORCE_TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // measurements, 0.1 % of rated voltage
    input wire logic [VW-1:0] u12_i,
    input wire logic [VW-1:0] u23_i,
    input wire logic [VW-1:0] u31_i,
    input wire logic [PVW-1:0] rated_primary_i,
    input wire logic [TSW-1:0] time_stamp_i,
    // blocking
    input wire logic [NUM_STAGES-1:0] block_i,
    // settings
    input wire logic [VW-1:0] pickup_i [NUM_STAGES][NUM_GROUPS],
    input wire logic [DW-1:0] delay_ms_i [NUM_STAGES][NUM_GROUPS],
    input wire logic [VW-1:0] low_volt_block_limit_i [NUM_STAGES][NUM_GROUPS],
    input wire logic [VW-1:0] hysteresis_i [NUM_STAGES],
    input wire logic [DW-1:0] release_delay_i,
    // group selection
    input wire logic [2:0] group_select_source_i,
    input wire logic [1:0] manual_group_i,
    input wire logic [1:0] digital_input_n_i,
    input wire logic [1:0] virtual_input_n_i,
    input wire logic [1:0] indicator_signal_n_i,
    input wire logic [1:0] virtual_output_n_i,
    // forcing
    input wire logic force_on_i,
    input wire logic force_off_i,
    input wire logic [NUM_STAGES-1:0] forced_start_i,
    input wire logic [NUM_STAGES-1:0] forced_trip_i,
    // fault log read
    input wire logic [1:0] log_stage_i,
    input wire logic [2:0] log_index_i,
    // stage outputs
    output wire logic [NUM_STAGES-1:0] start_o,
    output wire logic [NUM_STAGES-1:0] trip_o,
    output wire logic [3:0] stage_state_o [NUM_STAGES],
    output wire logic [CW-1:0] start_count_o [NUM_STAGES],
    output wire logic [CW-1:0] trip_count_o [NUM_STAGES],
    output wire logic [PVW-1:0] pickup_primary_o [NUM_STAGES],
    // shared status
    output logic [1:0] active_group_o,
    output logic force_o,
    output logic [PVW-1:0] min_line_voltage_o,
    output logic [VW-1:0] prefault_average_o,
    // fault log data
    output logic [TSW-1:0] log_time_o,
    output logic [VW-1:0] log_min_o,
    output logic [PW-1:0] elapsed_delay_pct_o,
    output logic [VW-1:0] log_prefault_o,
    output logic [1:0] log_group_o
);
    function automatic logic [PVW-1:0] to_primary(input logic [VW-1:0] v,
                                                  input logic [PVW-1:0] rated);
        logic [VW+PVW-1:0] prod;
        prod = (v * rated) / (VW+PVW)'(PERMILLE);
        return prod[PVW-1:0];
    endfunction : to_primary
    ////////////////////////////////////////////////////////////////////////////
    // extremes of the line voltages
    logic [VW-1:0] smallest_line_voltage;
    logic [VW-1:0] largest_line_voltage;
    always_comb begin
        smallest_line_voltage = u12_i;
        largest_line_voltage = u12_i;
        if (u23_i < smallest_line_voltage) smallest_line_voltage = u23_i;
        if (u31_i < smallest_line_voltage) smallest_line_voltage = u31_i;
        if (u23_i > largest_line_voltage) largest_line_voltage = u23_i;
        if (u31_i > largest_line_voltage) largest_line_voltage = u31_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    // millisecond tick, group select, force flag, pre-fault average
    logic [16:0] tick_cnt, next_tick_cnt;
    logic tick, next_tick;
    logic [1:0] di_meta, di_sync;
    logic [1:0] next_group;
    logic [18:0] force_cnt, next_force_cnt;
    logic next_force;
    logic [16:0] sample_cnt, next_sample_cnt;
    logic [PREFAULT_LOG2-1:0] sample_idx, next_sample_idx;
    logic [VW+PREFAULT_LOG2-1:0] avg_sum, next_avg_sum;
    logic [VW-1:0] next_prefault;
    always_comb begin
        next_tick = 1'b0;
        next_tick_cnt = tick_cnt + 17'h00001;
        if (tick_cnt == 17'(TICK_CYC - 1)) begin
            next_tick_cnt = '0;
            next_tick = 1'b1;
        end
        case (group_src_t'(group_select_source_i))
            SRC_DIGITAL: next_group = di_sync;
            SRC_VIRTUAL_IN: next_group = virtual_input_n_i;
            SRC_INDICATOR: next_group = indicator_signal_n_i;
            SRC_VIRTUAL_OUT: next_group = virtual_output_n_i;
            default: next_group = manual_group_i;
        endcase
        // set wins over timeout and explicit clear
        next_force = force_o;
        next_force_cnt = force_cnt;
        if (force_o && tick) next_force_cnt = force_cnt + 19'h00001;
        if (force_off_i || (force_o && force_cnt >= 19'(FORCE_TICKS))) next_force = 1'b0;
        if (force_on_i) begin
            next_force = 1'b1;
            next_force_cnt = '0;
        end
        if (!next_force) next_force_cnt = '0;
        // block average over the last complete second
        next_sample_cnt = sample_cnt + 17'h00001;
        next_sample_idx = sample_idx;
        next_avg_sum = avg_sum;
        next_prefault = prefault_average_o;
        if (sample_cnt == 17'(PREFAULT_SAMPLE_CYCLES - 1)) begin
            next_sample_cnt = '0;
            next_sample_idx = sample_idx + 1'b1;
            next_avg_sum = avg_sum + (VW+PREFAULT_LOG2)'(smallest_line_voltage);
            if (sample_idx == '1) begin
                next_prefault = next_avg_sum[VW+PREFAULT_LOG2-1:PREFAULT_LOG2];
                next_avg_sum = '0;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        di_meta <= digital_input_n_i;
        di_sync <= di_meta;
        if (srst_i) begin
            tick_cnt <= '0;
            tick <= 1'b0;
            active_group_o <= GROUP_RESET;
            force_o <= 1'b0;
            force_cnt <= '0;
            sample_cnt <= '0;
            sample_idx <= '0;
            avg_sum <= '0;
            prefault_average_o <= '0;
            min_line_voltage_o <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            active_group_o <= next_group;
            force_o <= next_force;
            force_cnt <= next_force_cnt;
            sample_cnt <= next_sample_cnt;
            sample_idx <= next_sample_idx;
            avg_sum <= next_avg_sum;
            prefault_average_o <= next_prefault;
            min_line_voltage_o <= to_primary(smallest_line_voltage, rated_primary_i);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // stages
    logic [TSW-1:0] rd_ts [NUM_STAGES];
    logic [VW-1:0] rd_min [NUM_STAGES];
    logic [PW-1:0] rd_pct [NUM_STAGES];
    logic [VW-1:0] rd_pre [NUM_STAGES];
    logic [1:0] rd_grp [NUM_STAGES];
    for (genvar s = 0; s < NUM_STAGES; s++) begin : stage_g
        stage_state_t state, next_state;
        logic start_q, next_start, trip_q, next_trip;
        logic [DW-1:0] timer, next_timer, rel_cnt, next_rel_cnt, dly, rel_lim;
        logic [CW-1:0] scnt, next_scnt, tcnt, next_tcnt;
        logic [PVW-1:0] pick_prim;
        logic [VW-1:0] pick, lvb, dband_min, next_dband_min;
        logic [2*VW-1:0] hprod;
        logic [VW+1:0] band;
        logic blocked, under, clear;
        logic [TSW-1:0] f_ts, next_f_ts;
        logic [VW-1:0] f_pre, next_f_pre;
        logic [1:0] f_grp, next_f_grp;
        logic log_we;
        logic [PW-1:0] log_pct;
        logic [DW+PW-1:0] pct_prod, pct_div;
        logic [2:0] wptr, rptr;
        logic [TSW-1:0] m_ts [LOG_DEPTH];
        logic [VW-1:0] m_min [LOG_DEPTH];
        logic [PW-1:0] m_pct [LOG_DEPTH];
        logic [VW-1:0] m_pre [LOG_DEPTH];
        logic [1:0] m_grp [LOG_DEPTH];
        assign pick = pickup_i[s][active_group_o];
        assign dly = delay_ms_i[s][active_group_o];
        assign lvb = low_volt_block_limit_i[s][active_group_o];
        assign rel_lim = (s == 0) ? release_delay_i : '0;
        assign hprod = pick * hysteresis_i[s];
        assign band = {2'b00, pick} + (VW+2)'(hprod / (2*VW)'(PERMILLE));
        assign blocked = block_i[s] || (lvb != '0 && largest_line_voltage < lvb);
        assign under = smallest_line_voltage < pick;
        assign clear = {2'b00, smallest_line_voltage} > band;
        assign pct_prod = (DW+PW)'(timer) * (DW+PW)'(FULL_PCT);
        assign pct_div = (dly == '0) ? (DW+PW)'(FULL_PCT) : pct_prod / (DW+PW)'(dly);
        always_comb begin
            next_state = state;
            next_timer = timer;
            next_rel_cnt = '0;
            next_scnt = scnt;
            next_tcnt = tcnt;
            next_dband_min = dband_min;
            next_f_ts = f_ts;
            next_f_pre = f_pre;
            next_f_grp = f_grp;
            log_we = 1'b0;
            log_pct = (pct_div > (DW+PW)'(FULL_PCT)) ? FULL_PCT : pct_div[PW-1:0];
            if (blocked) begin
                next_state = ST_BLOCKED;
            end else begin
                case (state)
                    ST_IDLE, ST_BLOCKED: next_state = under ? ST_STARTED : ST_IDLE;
                    ST_STARTED: begin
                        if (tick && timer != '1) next_timer = timer + 1'b1;
                        if (timer > dly) next_state = ST_TRIPPED;
                    end
                    ST_TRIPPED: next_state = ST_TRIPPED;
                    default: next_state = ST_IDLE;
                endcase
                if ((state == ST_STARTED || state == ST_TRIPPED) && clear) begin
                    next_rel_cnt = rel_cnt;
                    if (tick && rel_cnt != '1) next_rel_cnt = rel_cnt + 1'b1;
                    if (rel_cnt >= rel_lim) next_state = ST_IDLE;
                end
            end
            if (next_state == ST_STARTED && state != ST_STARTED) begin
                next_timer = '0;
                next_scnt = scnt + 1'b1;
                next_dband_min = smallest_line_voltage;
                next_f_ts = time_stamp_i;
                next_f_pre = prefault_average_o;
                next_f_grp = active_group_o;
            end else if (state == ST_STARTED && smallest_line_voltage < dband_min) begin
                next_dband_min = smallest_line_voltage;
            end
            if (state == ST_STARTED && next_state == ST_TRIPPED) begin
                next_tcnt = tcnt + 1'b1;
                log_we = 1'b1;
                log_pct = FULL_PCT;
            end else if (state == ST_STARTED && next_state != ST_STARTED) log_we = 1'b1;
            next_start = force_o ? forced_start_i[s]
                : (next_state == ST_STARTED || next_state == ST_TRIPPED);
            next_trip = force_o ? forced_trip_i[s] : (next_state == ST_TRIPPED);
        end
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                state <= ST_IDLE;
                start_q <= 1'b0;
                trip_q <= 1'b0;
                timer <= '0;
                rel_cnt <= '0;
                scnt <= COUNT_RESET;
                tcnt <= COUNT_RESET;
                dband_min <= '0;
                f_ts <= '0;
                f_pre <= '0;
                f_grp <= GROUP_RESET;
                wptr <= '0;
                pick_prim <= '0;
            end else begin
                state <= next_state;
                start_q <= next_start;
                trip_q <= next_trip;
                timer <= next_timer;
                rel_cnt <= next_rel_cnt;
                scnt <= next_scnt;
                tcnt <= next_tcnt;
                dband_min <= next_dband_min;
                f_ts <= next_f_ts;
                f_pre <= next_f_pre;
                f_grp <= next_f_grp;
                pick_prim <= to_primary(pick, rated_primary_i);
                if (log_we) wptr <= wptr + 1'b1;
            end
        end
        // log storage carries no reset; entries are meaningless until written
        always_ff @(posedge clk_i) begin
            if (log_we) begin
                m_ts[wptr] <= f_ts;
                m_min[wptr] <= dband_min;
                m_pct[wptr] <= log_pct;
                m_pre[wptr] <= f_pre;
                m_grp[wptr] <= f_grp;
            end
        end
        // index 0 is the latest fault
        assign rptr = wptr - 3'h1 - log_index_i;
        assign rd_ts[s] = m_ts[rptr];
        assign rd_min[s] = m_min[rptr];
        assign rd_pct[s] = m_pct[rptr];
        assign rd_pre[s] = m_pre[rptr];
        assign rd_grp[s] = m_grp[rptr];
        assign start_o[s] = start_q;
        assign trip_o[s] = trip_q;
        assign stage_state_o[s] = state;
        assign start_count_o[s] = scnt;
        assign trip_count_o[s] = tcnt;
        assign pickup_primary_o[s] = pick_prim;
    end
    ////////////////////////////////////////////////////////////////////////////
    // fault log read port
    logic [1:0] rsel;
    assign rsel = (log_stage_i >= 2'(NUM_STAGES)) ? 2'(NUM_STAGES - 1) : log_stage_i;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            log_time_o <= '0;
            log_min_o <= '0;
            elapsed_delay_pct_o <= '0;
            log_prefault_o <= '0;
            log_group_o <= GROUP_RESET;
        end else begin
            log_time_o <= rd_ts[rsel];
            log_min_o <= rd_min[rsel];
            elapsed_delay_pct_o <= rd_pct[rsel];
            log_prefault_o <= rd_pre[rsel];
            log_group_o <= rd_grp[rsel];
        end
    end
endmodule : undervoltage_protection_stages

// ---- src/uv_prot_pkg.sv ----
package uv_prot_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int NUM_STAGES = 3;
    localparam int NUM_GROUPS = 4;
    localparam int LOG_DEPTH = 8;
    localparam int VW = 12;
    localparam int DW = 16;
    localparam int CW = 16;
    localparam int TSW = 48;
    localparam int PW = 7;
    localparam int PVW = 16;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int FORCE_TIMEOUT_MIN = 5;
    localparam int FORCE_TIMEOUT_TICKS = FORCE_TIMEOUT_MIN * 60 * (1_000_000_000 / TICK_NS);
    localparam int PREFAULT_WINDOW_NS = 1_000_000_000;
    localparam int PREFAULT_LOG2 = 10;
    localparam int PREFAULT_SAMPLE_CYCLES =
        PREFAULT_WINDOW_NS / (1 << PREFAULT_LOG2) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // scaling and reset values
    localparam int PERMILLE = 1000;
    localparam logic [PW-1:0] FULL_PCT = 7'h64;
    localparam logic [VW-1:0] HYST_DEFAULT = 12'h01e;
    localparam logic [1:0] GROUP_RESET = 2'h0;
    localparam logic [CW-1:0] COUNT_RESET = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_BLOCKED = 4'b0010,
        ST_STARTED = 4'b0100,
        ST_TRIPPED = 4'b1000
    } stage_state_t;

    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_DIGITAL = 3'h1,
        SRC_VIRTUAL_IN = 3'h2,
        SRC_INDICATOR = 3'h3,
        SRC_VIRTUAL_OUT = 3'h4
    } group_src_t;

endpackage : uv_prot_pkg

// ---- test/uv_prot_checker.sv ----
`timescale 1ns/100ps
module uv_prot_checker
    import uv_prot_pkg::*;
(
    // clock and stimulus
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [VW-1:0] u12_i,
    input wire logic [VW-1:0] u23_i,
    input wire logic [VW-1:0] u31_i,
    input wire logic [NUM_STAGES-1:0] block_i,
    input wire logic [VW-1:0] pickup_i [NUM_STAGES][NUM_GROUPS],
    input wire logic [VW-1:0] low_volt_block_limit_i [NUM_STAGES][NUM_GROUPS],
    input wire logic [2:0] group_select_source_i,
    input wire logic [1:0] manual_group_i,
    // watched outputs
    input wire logic [NUM_STAGES-1:0] start_o,
    input wire logic [NUM_STAGES-1:0] trip_o,
    input wire logic [3:0] stage_state_o [NUM_STAGES],
    input wire logic [CW-1:0] start_count_o [NUM_STAGES],
    input wire logic [CW-1:0] trip_count_o [NUM_STAGES],
    input wire logic [1:0] active_group_o,
    input wire logic force_o
);
    // only stage 0 is watched; the others share its logic
    logic [VW-1:0] lo, hi, pick, lim;
    logic [3:0] st;
    assign lo = (u12_i < u23_i) ? ((u12_i < u31_i) ? u12_i : u31_i)
        : ((u23_i < u31_i) ? u23_i : u31_i);
    assign hi = (u12_i > u23_i) ? ((u12_i > u31_i) ? u12_i : u31_i)
        : ((u23_i > u31_i) ? u23_i : u31_i);
    assign pick = pickup_i[0][active_group_o];
    assign lim = low_volt_block_limit_i[0][active_group_o];
    assign st = stage_state_o[0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////////
    a_under_starts: assert property (st == 4'b0001 && !block_i[0] && lo < pick &&
        (lim == 12'h000 || hi >= lim) |=> st == 4'b0100) else $error("stage did not start");
    a_start_counted: assert property (st == 4'b0100 && $past(st) == 4'b0001 |->
        start_count_o[0] == $past(start_count_o[0]) + 16'h0001) else $error("start count");
    a_trip_after_start: assert property (st == 4'b1000 && $past(st) != 4'b1000 |->
        $past(st) == 4'b0100 && trip_count_o[0] == $past(trip_count_o[0]) + 16'h0001)
        else $error("trip without start");
    a_block_drops: assert property (block_i[0] && !force_o ##1 !force_o |->
        st == 4'b0010 && !start_o[0] && !trip_o[0]) else $error("blocked stage active");
    a_self_block: assert property (lim != 12'h000 && hi < lim |=> st == 4'b0010)
        else $error("no self block");
    a_zero_limit: assert property (lim == 12'h000 && !block_i[0] |=> st != 4'b0010)
        else $error("self block with zero limit");
    a_state_onehot: assert property ($onehot(st)) else $error("state not one-hot");
    a_group_manual: assert property (group_select_source_i == 3'h0 ##1
        group_select_source_i == 3'h0 |-> active_group_o == $past(manual_group_i))
        else $error("manual group not taken");
endmodule : uv_prot_checker

bind undervoltage_protection_stages uv_prot_checker uv_prot_checker_i (
    .clk_i(clk_i), .srst_i(srst_i), .u12_i(u12_i), .u23_i(u23_i), .u31_i(u31_i),
    .block_i(block_i), .pickup_i(pickup_i), .low_volt_block_limit_i(low_volt_block_limit_i),
    .group_select_source_i(group_select_source_i), .manual_group_i(manual_group_i),
    .start_o(start_o), .trip_o(trip_o), .stage_state_o(stage_state_o),
    .start_count_o(start_count_o), .trip_count_o(trip_count_o),
    .active_group_o(active_group_o), .force_o(force_o)
);

// ---- test/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    import uv_prot_pkg::*;
    // short tick and force timeout keep the run small
    localparam int TK = 10;
    localparam int FT = 20;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [VW-1:0] u12_i, u23_i, u31_i, log_min_o, log_prefault_o, prefault_average_o;
    logic [PVW-1:0] rated_primary_i, min_line_voltage_o;
    logic [TSW-1:0] time_stamp_i = 48'h0, log_time_o;
    logic [NUM_STAGES-1:0] block_i, forced_start_i, forced_trip_i, start_o, trip_o;
    logic [VW-1:0] pickup_i [NUM_STAGES][NUM_GROUPS];
    logic [DW-1:0] delay_ms_i [NUM_STAGES][NUM_GROUPS];
    logic [VW-1:0] low_volt_block_limit_i [NUM_STAGES][NUM_GROUPS];
    logic [VW-1:0] hysteresis_i [NUM_STAGES];
    logic [DW-1:0] release_delay_i;
    logic [2:0] group_select_source_i, log_index_i;
    logic [1:0] manual_group_i, digital_input_n_i, virtual_input_n_i, indicator_signal_n_i;
    logic [1:0] virtual_output_n_i, log_stage_i, active_group_o, log_group_o;
    logic force_on_i, force_off_i, force_o;
    logic [3:0] stage_state_o [NUM_STAGES];
    logic [CW-1:0] start_count_o [NUM_STAGES];
    logic [CW-1:0] trip_count_o [NUM_STAGES];
    logic [PVW-1:0] pickup_primary_o [NUM_STAGES];
    logic [PW-1:0] elapsed_delay_pct_o;
    int error_cnt = 0;
    int cmp_count = 0;

    undervoltage_protection_stages #(.TICK_CYC(TK), .FORCE_TICKS(FT))
        undervoltage_protection_stages_i (
        .clk_i(clk_i), .srst_i(srst_i), .u12_i(u12_i), .u23_i(u23_i), .u31_i(u31_i),
        .rated_primary_i(rated_primary_i), .time_stamp_i(time_stamp_i), .block_i(block_i),
        .pickup_i(pickup_i), .delay_ms_i(delay_ms_i),
        .low_volt_block_limit_i(low_volt_block_limit_i), .hysteresis_i(hysteresis_i),
        .release_delay_i(release_delay_i), .group_select_source_i(group_select_source_i),
        .manual_group_i(manual_group_i), .digital_input_n_i(digital_input_n_i),
        .virtual_input_n_i(virtual_input_n_i), .indicator_signal_n_i(indicator_signal_n_i),
        .virtual_output_n_i(virtual_output_n_i), .force_on_i(force_on_i),
        .force_off_i(force_off_i), .forced_start_i(forced_start_i),
        .forced_trip_i(forced_trip_i), .log_stage_i(log_stage_i), .log_index_i(log_index_i),
        .start_o(start_o), .trip_o(trip_o), .stage_state_o(stage_state_o),
        .start_count_o(start_count_o), .trip_count_o(trip_count_o),
        .pickup_primary_o(pickup_primary_o), .active_group_o(active_group_o),
        .force_o(force_o), .min_line_voltage_o(min_line_voltage_o),
        .prefault_average_o(prefault_average_o), .log_time_o(log_time_o),
        .log_min_o(log_min_o), .elapsed_delay_pct_o(elapsed_delay_pct_o),
        .log_prefault_o(log_prefault_o), .log_group_o(log_group_o)
    );

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    always @(posedge clk_i) time_stamp_i <= time_stamp_i + 48'h1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic setu(input logic [VW-1:0] a, input logic [VW-1:0] b, input logic [VW-1:0] c);
        u12_i = a;
        u23_i = b;
        u31_i = c;
    endtask : setu

    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(stage_state_o[0], 4'b0001, "idle after reset");
        chk(start_count_o[0], 16'h0000, "start count reset");
        chk(active_group_o, 2'h0, "group reset");
        chk(force_o, 1'b0, "force reset");
        $display("test reset done");
    endtask : t_reset

    task automatic t_start_trip;
        setu(12'h1f4, 12'h3e8, 12'h3e8);
        tick(1);
        chk(start_o, 3'b011, "two stages start");
        chk(stage_state_o[0], 4'b0100, "started");
        tick(2 * TK - 2);
        chk(trip_o[0], 1'b0, "trip too early");
        tick(2 * TK + 4);
        chk(trip_o, 3'b001, "trip after delay");
        chk(trip_count_o[0], 16'h0001, "trip count");
        chk(min_line_voltage_o, 16'h1388, "min primary");
        chk(pickup_primary_o[0], 16'h1f40, "pickup primary");
        chk(log_min_o, 12'h1f4, "log min");
        chk(elapsed_delay_pct_o, 7'h64, "log pct trip");
        chk(log_group_o, 2'h0, "log group");
        chk(log_time_o, 48'h7, "log time");
        chk(log_prefault_o, 12'h000, "log prefault");
        setu(12'h3e8, 12'h3e8, 12'h3e8);
        tick(3);
        chk(stage_state_o[0], 4'b0001, "released");
        $display("test start trip done");
    endtask : t_start_trip

    task automatic t_block;
        block_i = 3'b001;
        setu(12'h1f4, 12'h3e8, 12'h3e8);
        tick(2);
        chk(stage_state_o[0], 4'b0010, "blocked");
        chk(start_o, 3'b010, "blocked no start");
        block_i = 3'b000;
        tick(2);
        chk(stage_state_o[0], 4'b0100, "start after block");
        setu(12'h3e8, 12'h3e8, 12'h3e8);
        tick(3);
        $display("test block done");
    endtask : t_block

    task automatic t_self_block;
        setu(12'h096, 12'h096, 12'h096);
        tick(2);
        chk(stage_state_o[0], 4'b0010, "self blocked");
        for (int g = 0; g < NUM_GROUPS; g++) low_volt_block_limit_i[0][g] = 12'h000;
        tick(2);
        chk(stage_state_o[0], 4'b0100, "zero limit starts");
        for (int g = 0; g < NUM_GROUPS; g++) low_volt_block_limit_i[0][g] = 12'h0c8;
        setu(12'h3e8, 12'h3e8, 12'h3e8);
        tick(3);
        setu(12'h12c, 12'h3e8, 12'h3e8);
        tick(2);
        chk(stage_state_o[0], 4'b0100, "between limits");
        setu(12'h3e8, 12'h3e8, 12'h3e8);
        tick(3);
        $display("test self block done");
    endtask : t_self_block

    task automatic t_hyst;
        setu(12'h1f4, 12'h3e8, 12'h3e8);
        tick(2);
        setu(12'h334, 12'h3e8, 12'h3e8);
        tick(3);
        chk(stage_state_o[0], 4'b0100, "inside dead band");
        setu(12'h33e, 12'h3e8, 12'h3e8);
        tick(3);
        chk(stage_state_o[0], 4'b0001, "above dead band");
        chk(elapsed_delay_pct_o < 7'h64, 1'b1, "partial pct");
        $display("test dead band done");
    endtask : t_hyst

    task automatic t_group;
        logic [1:0] exp [5] = '{2'h2, 2'h1, 2'h3, 2'h2, 2'h1};
        manual_group_i = 2'h2;
        for (int s = 0; s < 5; s++) begin
            group_select_source_i = 3'(s);
            tick(4);
            chk(active_group_o, exp[s], "group source");
        end
        group_select_source_i = 3'h0;
        manual_group_i = 2'h0;
        tick(2);
        $display("test group done");
    endtask : t_group

    task automatic t_force;
        forced_start_i = 3'b101;
        forced_trip_i = 3'b010;
        force_on_i = 1'b1;
        tick(1);
        force_on_i = 1'b0;
        tick(2);
        chk(force_o, 1'b1, "force set");
        chk({start_o, trip_o}, 6'b101010, "forced outputs");
        tick((FT + 2) * TK);
        chk(force_o, 1'b0, "force timeout");
        force_on_i = 1'b1;
        tick(1);
        force_on_i = 1'b0;
        force_off_i = 1'b1;
        tick(1);
        force_off_i = 1'b0;
        tick(2);
        chk(force_o, 1'b0, "force off");
        $display("test force done");
    endtask : t_force

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        setu(12'h3e8, 12'h3e8, 12'h3e8);
        rated_primary_i = 16'h2710;
        {block_i, forced_start_i, forced_trip_i} = 9'h000;
        {force_on_i, force_off_i, release_delay_i} = 18'h00000;
        {group_select_source_i, log_index_i, log_stage_i} = 8'h00;
        {manual_group_i, digital_input_n_i, virtual_input_n_i} = 6'b000111;
        {indicator_signal_n_i, virtual_output_n_i} = 4'b1001;
        for (int s = 0; s < NUM_STAGES; s++) begin
            hysteresis_i[s] = HYST_DEFAULT;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                pickup_i[s][g] = (s == 0) ? 12'h320 : (s == 1) ? 12'h258 : 12'h12c;
                delay_ms_i[s][g] = (s == 0) ? 16'h0002 : 16'h03e8;
                low_volt_block_limit_i[s][g] = 12'h0c8;
            end
        end
        manual_group_i = 2'h0;
        tick(6);
        srst_i = 1'b0;
        tick(1);
        t_reset();
        t_start_trip();
        t_block();
        t_self_block();
        t_hyst();
        t_group();
        t_force();
        test_done();
    end

    initial begin
        #(CLK_PERIOD_NS * 5000);
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule : testbench
